// ### rtl/channel_sequencer_clock_counter.sv
// channel configuration registers, round-robin sequencer and clock tick counter
// assumes the serial port front end and converter run on clk and
// deliver one-cycle request and done pulses
`timescale 1ns/10ps
`include "seq_cfg.svh"

// Overview of operation
// - tick counter steps once every 131 main clock cycles
// - tick counter is 8 bits and wraps to zero silently
// - register 0x08 returns the running count only while counting is enabled
// - tick register is bits 7:0, read-only, zero after reset
// - channel register bit 23 puts the channel in the sequence
// - reset: channel zero 0x800100, all others 0x000100
// - sequence starts at lowest enabled channel, climbs, then wraps to lowest
// - on each result while the sequencer runs, the channel number goes into the status tag
// - bits 22:20 pick one of eight setups for the channel
// - several channels may share one setup select value
// - channel k register sits at 0x09 plus k, up to 0x18
module channel_sequencer_clock_counter #(
  parameter int NCH = 16,
  parameter int TICK_DIV = `TICK_DIV
) (
  // clock, reset, freeze
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // counter enable from the error enable register
  input wire logic tick_counter_enable,
  // register access
  input seq_pkg::reg_req_t reg_req,
  output logic [23:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // converter handshake
  input wire logic seq_restart,
  input wire logic conv_done,
  // sequencer state
  output logic seq_busy_q,
  output logic [3:0] cur_chan_q,
  output logic [2:0] cur_setup_q,
  output logic [3:0] status_chan_q
);
  import seq_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [3:0] next_chan(input logic [NCH-1:0] mask, input logic [3:0] from);
    logic [3:0] res;
    logic found;
    logic [3:0] idx;
    res = from;
    found = 1'b0;
    for (int k = 1; k <= NCH; k++) begin
      idx = 4'(int'(from) + k);
      if (!found && mask[idx]) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // searching from the top channel yields the lowest enabled one
  function automatic logic [3:0] lowest_chan(input logic [NCH-1:0] mask);
    return next_chan(mask, 4'(NCH - 1));
  endfunction

  function automatic logic [23:0] reset_val(input int k);
    return (k == 0) ? `CH0_RESET : `CHM_RESET;
  endfunction

  function automatic logic [23:0] wmask(input int k);
    return (k == 0) ? `CH0_WMASK : `CHM_WMASK;
  endfunction

  // ==========================================================
  // tick counter
  logic [`TICK_W-1:0] tick_count;

  tick_counter #(
    .DIV(TICK_DIV),
    .W(`TICK_W)
  ) i_tick_counter (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .enable(tick_counter_enable),
    .count_q(tick_count)
  );

  // ==========================================================
  // channel registers
  logic [NCH-1:0][23:0] cfg_q;
  logic [NCH-1:0] en_mask;
  logic ch_hit;
  logic [3:0] ch_idx;
  logic rsvd_any;

  assign ch_hit = (reg_req.addr >= `ADDR_CH_BASE) && (reg_req.addr <= `ADDR_CH_LAST);
  assign ch_idx = 4'(reg_req.addr - `ADDR_CH_BASE);

  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      en_mask[k] = cfg_q[k][`CH_ENABLE_BIT];
    end
  end

  // reserved bits are masked on write, so any set bit here means a broken mask
  always_comb begin
    rsvd_any = 1'b0;
    for (int k = 0; k < NCH; k++) begin
      rsvd_any = rsvd_any | (|(cfg_q[k] & ~wmask(k)));
    end
  end

  // a write lands at the taking edge and returns no answer
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < NCH; k++) begin
        cfg_q[k] <= reset_val(k);
      end
    end else if (ce && reg_req.wr && ch_hit) begin
      // reserved bits stay zero whatever is written
      cfg_q[ch_idx] <= reg_req.wdata & wmask(int'(ch_idx));
    end
  end

  // ==========================================================
  // register read path; writes to the tick address fall through untouched
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= 24'h000000;
      reg_rvalid_q <= 1'b0;
    end else if (ce) begin
      reg_rvalid_q <= reg_req.rd;
      if (reg_req.rd) begin
        if (reg_req.addr == `ADDR_TICK) begin
          // counter is held at zero while disabled, so it reads zero then
          reg_rdata_q <= {16'h0000, tick_count};
        end else if (ch_hit) begin
          reg_rdata_q <= cfg_q[ch_idx];
        end else begin
          reg_rdata_q <= 24'h000000;
        end
      end
    end
  end

  // ==========================================================
  // sequencer
  seq_state_t state_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SEQ_IDLE;
      cur_chan_q <= 4'h0;
    end else if (ce) begin
      case (state_q)
        SEQ_IDLE: begin
          if (seq_restart && |en_mask) begin
            state_q <= SEQ_RUN;
            cur_chan_q <= lowest_chan(en_mask);
          end
        end
        SEQ_RUN: begin
          if (!(|en_mask)) begin
            state_q <= SEQ_IDLE;
          end else if (seq_restart) begin
            cur_chan_q <= lowest_chan(en_mask);
          end else if (conv_done) begin
            // wraps past the top back to the lowest enabled channel
            cur_chan_q <= next_chan(en_mask, cur_chan_q);
          end
        end
        default: begin
          state_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  // busy lags the state by one cycle so that it leaves straight from a flip-flop
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_busy_q <= 1'b0;
    end else if (ce) begin
      seq_busy_q <= (state_q == SEQ_RUN);
    end
  end

  // setup select trails the channel by one cycle; the converter samples it at start
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_setup_q <= 3'h0;
    end else if (ce) begin
      cur_setup_q <= cfg_q[cur_chan_q][`CH_SETUP_MSB:`CH_SETUP_LSB];
    end
  end

  // results strobed while idle are dropped: no channel owns them
  always_ff @(posedge clk) begin
    if (rst) begin
      status_chan_q <= 4'h0;
    end else if (ce && conv_done && state_q == SEQ_RUN) begin
      status_chan_q <= cur_chan_q;
    end
  end

  // ==========================================================
  // checks
  a_reset_values: assert property (@(posedge clk)
    rst |=> (cfg_q[0] == `CH0_RESET && cfg_q[NCH-1] == `CHM_RESET && en_mask == 16'h0001))
    else $error("channel registers not at reset values");
  a_tick_read: assert property (@(posedge clk) disable iff (rst)
    (ce && reg_req.rd && reg_req.addr == `ADDR_TICK) |=>
      (reg_rvalid_q && reg_rdata_q == {16'h0000, $past(tick_count)}))
    else $error("tick register read returned wrong value");
  a_tick_gated: assert property (@(posedge clk) disable iff (rst)
    (ce && reg_req.rd && reg_req.addr == `ADDR_TICK && !tick_counter_enable) ##1
      (ce && reg_req.rd && reg_req.addr == `ADDR_TICK) |=> (reg_rdata_q == 24'h000000))
    else $error("tick register nonzero while counting disabled");
  a_tick_readonly: assert property (@(posedge clk) disable iff (rst)
    (reg_req.wr && !ch_hit) |=> $stable(cfg_q))
    else $error("write outside channel range changed a register");
  a_cfg_write: assert property (@(posedge clk) disable iff (rst)
    (ce && reg_req.wr && ch_hit) |=> (cfg_q[$past(ch_idx)] == ($past(reg_req.wdata) & wmask(int'($past(ch_idx))))))
    else $error("channel register write not stored at decoded index");
  a_seq_advance: assert property (@(posedge clk) disable iff (rst)
    (ce && state_q == SEQ_RUN && conv_done && !seq_restart && |en_mask) |=>
      (cur_chan_q == next_chan($past(en_mask), $past(cur_chan_q)) && en_mask[cur_chan_q]))
    else $error("sequencer did not step to next enabled channel");
  a_seq_start_low: assert property (@(posedge clk) disable iff (rst)
    (ce && seq_restart && |en_mask) |=> (cur_chan_q == lowest_chan($past(en_mask)) && state_q == SEQ_RUN))
    else $error("sequence did not start at lowest enabled channel");
  a_status_tag: assert property (@(posedge clk) disable iff (rst)
    (ce && conv_done && state_q == SEQ_RUN) |=> (status_chan_q == $past(cur_chan_q)))
    else $error("status tag does not name the converted channel");
  a_setup_follow: assert property (@(posedge clk) disable iff (rst)
    (ce && $stable(cur_chan_q)) |=> (cur_setup_q == $past(cfg_q[cur_chan_q][`CH_SETUP_MSB:`CH_SETUP_LSB])))
    else $error("setup select does not follow channel register");
  a_disable_idle: assert property (@(posedge clk) disable iff (rst)
    (ce && state_q == SEQ_RUN && en_mask == '0) |=> (state_q == SEQ_IDLE) ##1 (!seq_busy_q || !$past(ce)))
    else $error("sequencer kept running with no channel enabled");

  // ==========================================================
  // sequencer ordering, partly checked without the search helpers
  a_idle_no_tag: assert property (@(posedge clk) disable iff (rst)
    (ce && state_q == SEQ_IDLE) |=> $stable(status_chan_q))
    else $error("status tag changed while the sequencer was idle");
  a_busy_idle: assert property (@(posedge clk) disable iff (rst)
    (ce && state_q == SEQ_IDLE) |=> !seq_busy_q)
    else $error("busy raised while the sequencer was idle");
  a_idle_hold: assert property (@(posedge clk) disable iff (rst)
    (ce && state_q == SEQ_IDLE && !(seq_restart && |en_mask)) |=>
      (state_q == SEQ_IDLE && $stable(cur_chan_q)))
    else $error("sequencer left idle without a restart");
  a_restart_wins: assert property (@(posedge clk) disable iff (rst)
    (ce && state_q == SEQ_RUN && seq_restart && conv_done && |en_mask) |=>
      (cur_chan_q == lowest_chan($past(en_mask))))
    else $error("result strobe overrode a restart");
  a_start_lowest: assert property (@(posedge clk) disable iff (rst)
    (ce && seq_restart && |en_mask && !reg_req.wr) |=>
      (en_mask[cur_chan_q] && (en_mask & ((NCH'(1) << cur_chan_q) - NCH'(1))) == '0))
    else $error("an enabled channel lies below the restart channel");

  // ==========================================================
  // bus and freeze: ce low must leave every register exactly as it was
  a_freeze_cfg: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(cfg_q))
    else $error("channel registers moved while clock enable was low");
  a_freeze_seq: assert property (@(posedge clk) disable iff (rst)
    !ce |=> ($stable(cur_chan_q) && $stable(status_chan_q) && $stable(seq_busy_q) && $stable(cur_setup_q)))
    else $error("sequencer outputs moved while clock enable was low");
  a_freeze_read: assert property (@(posedge clk) disable iff (rst)
    !ce |=> ($stable(reg_rvalid_q) && $stable(reg_rdata_q)))
    else $error("read port moved while clock enable was low");
  a_read_pulse: assert property (@(posedge clk) disable iff (rst)
    (ce && !reg_req.rd) |=> !reg_rvalid_q)
    else $error("read valid raised without a read request");
  a_read_unmapped: assert property (@(posedge clk) disable iff (rst)
    (ce && reg_req.rd && reg_req.addr != `ADDR_TICK && !ch_hit) |=> (reg_rdata_q == 24'h000000))
    else $error("unmapped address read back nonzero");
  a_cfg_read: assert property (@(posedge clk) disable iff (rst)
    (ce && reg_req.rd && ch_hit) |=> (reg_rdata_q == $past(cfg_q[ch_idx])))
    else $error("channel register read returned wrong word");
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    !rsvd_any)
    else $error("reserved channel register bit is set");

  // ==========================================================
  // tick register view
  a_tick_upper: assert property (@(posedge clk) disable iff (rst)
    (ce && reg_req.rd && reg_req.addr == `ADDR_TICK) |=> (reg_rdata_q[23:8] == 16'h0000))
    else $error("tick register read set bits above the count");

  c_seq_wrap: cover property (@(posedge clk) disable iff (rst)
    ce && conv_done && state_q == SEQ_RUN && next_chan(en_mask, cur_chan_q) < cur_chan_q);
  c_seq_restart: cover property (@(posedge clk) disable iff (rst)
    ce && seq_restart && state_q == SEQ_RUN);
  c_tick_readback: cover property (@(posedge clk) disable iff (rst)
    reg_rvalid_q && $past(reg_req.addr) == `ADDR_TICK && reg_rdata_q != 24'h000000);
  c_shared_setup: cover property (@(posedge clk) disable iff (rst)
    en_mask[0] && en_mask[1] && cfg_q[0][22:20] == cfg_q[1][22:20] && cfg_q[0][22:20] != 3'h0);

endmodule // channel_sequencer_clock_counter

// ### rtl/seq_cfg.svh
// constants for the channel sequencer and clock tick counter
// assumes inclusion by bare name from rtl/ before any module that uses it
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

// ==========================================================
// register map
`define REG_AW 6
`define ADDR_TICK 6'h08
`define ADDR_CH_BASE 6'h09
`define ADDR_CH_LAST 6'h18

// ==========================================================
// channel register fields and reset values
`define CH_ENABLE_BIT 23
`define CH_SETUP_MSB 22
`define CH_SETUP_LSB 20
`define CH0_RESET 24'h800100
`define CHM_RESET 24'h000100
// bit 18 always reserved, bit 19 reserved on channel zero only
`define CH0_WMASK 24'hF3FFFF
`define CHM_WMASK 24'hFBFFFF

// ==========================================================
// tick counter timing
`define TICK_DIV 131
`define TICK_W 8

`endif

// ### rtl/seq_pkg.sv
// types shared by the channel sequencer and clock tick counter
// assumes seq_cfg.svh sits beside it
`include "seq_cfg.svh"

package seq_pkg;

  // ==========================================================
  // register access request from the serial port front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`REG_AW-1:0] addr;
    logic [23:0] wdata;
  } reg_req_t;

  // ==========================================================
  // sequencer state
  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_RUN
  } seq_state_t;

endpackage

// ### rtl/tick_counter.sv
// main clock tick counter: prescaler plus wrapping count
// assumes clk is the main clock and enable comes from same-clock logic
`timescale 1ns/10ps
`include "seq_cfg.svh"

module tick_counter #(
  parameter int DIV = `TICK_DIV,
  parameter int W = `TICK_W
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  // count
  output logic [W-1:0] count_q
);

  localparam int PW = $clog2(DIV);
  localparam logic [PW-1:0] PRE_LAST = PW'(DIV - 1);

  logic [PW-1:0] pre_q;
  logic tick;

  assign tick = (pre_q == PRE_LAST);

  // ==========================================================
  // prescaler
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= '0;
    end else if (ce) begin
      if (!enable || tick) begin
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // count: cleared while disabled so a fresh enable starts at zero
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (ce) begin
      if (!enable) begin
        count_q <= '0;
      end else if (tick) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // checks
  a_tick_step: assert property (@(posedge clk) disable iff (rst)
    (ce && enable && tick) |=> (count_q == W'($past(count_q) + 1)))
    else $error("tick count did not step after prescaler wrap");
  a_tick_hold: assert property (@(posedge clk) disable iff (rst)
    (enable && !(ce && tick)) |=> $stable(count_q))
    else $error("tick count moved between prescaler wraps");
  a_tick_wrap: assert property (@(posedge clk) disable iff (rst)
    (ce && enable && tick && count_q == '1) |=> (count_q == '0))
    else $error("tick count did not roll over to zero");
  a_tick_clear: assert property (@(posedge clk) disable iff (rst)
    (ce && !enable) |=> (count_q == '0 && pre_q == '0))
    else $error("tick count not cleared while disabled");
  c_tick_wrap: cover property (@(posedge clk) disable iff (rst)
    ce && enable && tick && count_q == '1);

endmodule // tick_counter

// ### tb/test_channel_sequencer_clock_counter.sv
// self-checking bench for the channel sequencer and clock tick counter
// assumes rtl/ on the include path; the tick divider runs at full length
`timescale 1ns/10ps
`include "seq_cfg.svh"

module test_channel_sequencer_clock_counter;
  import seq_pkg::*;
  localparam int DIV = `TICK_DIV;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic tick_counter_enable = 1'b0;
  reg_req_t reg_req = '0;
  logic seq_restart = 1'b0;
  logic conv_done = 1'b0;
  logic [23:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic seq_busy_q;
  logic [3:0] cur_chan_q;
  logic [2:0] cur_setup_q;
  logic [3:0] status_chan_q;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int k;

  // ==========================================================
  // design
  channel_sequencer_clock_counter #(.NCH(16), .TICK_DIV(DIV)) i_channel_sequencer_clock_counter (
    .clk(clk), .rst(rst), .ce(ce), .tick_counter_enable(tick_counter_enable),
    .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .seq_restart(seq_restart), .conv_done(conv_done), .seq_busy_q(seq_busy_q),
    .cur_chan_q(cur_chan_q), .cur_setup_q(cur_setup_q), .status_chan_q(status_chan_q)
  );

  // ==========================================================
  // clock and hang guard
  initial begin
    forever #25 clk = ~clk;
  end

  // whole run needs about 35,000 cycles, mostly one pass past 256 tick steps
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end

  // ==========================================================
  // tasks
  task complete_run;
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // extra idle cycle keeps back-to-back calls from driving twice in one step
  task reg_write(input logic [5:0] a, input logic [23:0] d);
    reg_req = {1'b1, 1'b0, a, d};
    @(negedge clk);
    reg_req = '0;
    @(negedge clk);
  endtask

  task reg_read(input logic [5:0] a, input logic [23:0] exp);
    int n;
    reg_req = {1'b0, 1'b1, a, 24'h000000};
    @(negedge clk);
    reg_req = '0;
    n = 0;
    while (reg_rvalid_q !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    check(reg_rvalid_q === 1'b1 ? reg_rdata_q : 24'hXXXXXX, exp);
    @(negedge clk);
  endtask

  task seq_step(input logic r, input logic d);
    seq_restart = r;
    conv_done = d;
    @(negedge clk);
    seq_restart = 1'b0;
    conv_done = 1'b0;
    @(negedge clk);
  endtask

  task seq_check(input logic [3:0] ch, input logic [2:0] su, input logic [3:0] st);
    check({20'h0, cur_chan_q}, {20'h0, ch});
    check({21'h0, cur_setup_q}, {21'h0, su});
    check({20'h0, status_chan_q}, {20'h0, st});
  endtask

  // restart counting, then read three cycles after the last requested step
  task tick_probe(input int steps, input logic [23:0] exp);
    tick_counter_enable = 1'b0;
    repeat (2) @(negedge clk);
    tick_counter_enable = 1'b1;
    repeat (DIV * steps + 2) @(negedge clk);
    reg_read(`ADDR_TICK, exp);
  endtask

  // ==========================================================
  // scenarios
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    reg_read(`ADDR_CH_BASE, `CH0_RESET);
    for (k = 1; k < 16; k++) begin
      reg_read(6'(`ADDR_CH_BASE + k), `CHM_RESET);
    end
    reg_read(`ADDR_TICK, 24'h000000);
    reg_write(`ADDR_TICK, 24'hFFFFFF);
    reg_read(`ADDR_TICK, 24'h000000);
    reg_read(6'h19, 24'h000000);
    // distinct words per channel expose any decode overlap
    for (k = 0; k < 16; k++) begin
      reg_write(6'(`ADDR_CH_BASE + k), 24'h7FFFFF ^ 24'(k));
    end
    for (k = 0; k < 16; k++) begin
      reg_read(6'(`ADDR_CH_BASE + k), (24'h7FFFFF ^ 24'(k)) & (k == 0 ? `CH0_WMASK : `CHM_WMASK));
    end
    seq_step(1'b0, 1'b1);
    check({23'h0, seq_busy_q}, 24'h000000);
    check({20'h0, status_chan_q}, 24'h000000);
    reg_write(6'h0B, 24'hB00000);
    reg_write(6'h0E, 24'hB00000);
    reg_write(6'h12, 24'hE00000);
    seq_step(1'b1, 1'b0);
    check({23'h0, seq_busy_q}, 24'h000001);
    seq_check(4'h2, 3'h3, 4'h0);
    for (k = 0; k < 8; k++) begin
      reg_write(6'h0B, {1'b1, 3'(k), 20'h00000});
      @(negedge clk);
      check({21'h0, cur_setup_q}, 24'(k));
    end
    seq_step(1'b0, 1'b1);
    seq_check(4'h5, 3'h3, 4'h2);
    seq_step(1'b0, 1'b1);
    seq_check(4'h9, 3'h6, 4'h5);
    seq_step(1'b0, 1'b1);
    seq_check(4'h2, 3'h7, 4'h9);
    seq_step(1'b1, 1'b1);
    check({20'h0, cur_chan_q}, 24'h000002);
    check({20'h0, status_chan_q}, 24'h000002);
    // freeze: a write and a result strobe offered with ce low leave no trace
    ce = 1'b0;
    reg_write(6'h0B, 24'h000000);
    seq_step(1'b0, 1'b1);
    ce = 1'b1;
    reg_read(6'h0B, 24'hF00000);
    seq_check(4'h2, 3'h7, 4'h2);
    seq_step(1'b0, 1'b1);
    // all channels off: the sequencer drops to idle and ignores further results
    reg_write(6'h0B, 24'h000000);
    reg_write(6'h0E, 24'h000000);
    reg_write(6'h12, 24'h000000);
    seq_step(1'b0, 1'b1);
    check({23'h0, seq_busy_q}, 24'h000000);
    seq_check(4'h5, 3'h0, 4'h2);
    tick_probe(3, 24'h000003);
    tick_probe(255, 24'h0000FF);
    // two more steps at the same prescaler phase carry the count past 0xFF
    repeat (2 * DIV - 2) @(negedge clk);
    reg_read(`ADDR_TICK, 24'h000001);
    tick_counter_enable = 1'b0;
    repeat (2) @(negedge clk);
    reg_read(`ADDR_TICK, 24'h000000);
    tick_probe(1, 24'h000001);
    // reset in mid-run restores the register defaults and clears the count
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    reg_read(`ADDR_CH_BASE, `CH0_RESET);
    reg_read(6'h0B, `CHM_RESET);
    reg_read(`ADDR_TICK, 24'h000000);
    complete_run();
  end
endmodule // test_channel_sequencer_clock_counter
